// File: rtl/cpu_state_exception_bus_seq.sv
// CPU state sequencer: reset and interrupt entry, power-down modes, and
// the two- and three-state bus cycles that push, fetch and access memory.
// Assumes the CPU core reports instruction ends and sleep execution on
// pclk, and that pins arrive asynchronously.
//
// How it works
// (RULE1) Only reset and interrupt exceptions exist; reset wins.
// (RULE2) Interrupt entry pushes PC then COND_CODE_REG; reset skips the pushes.
// (RULE3) Every exception sequence sets the interrupt mask flag.
// (RULE4) Vector is fetched, PC loaded, then normal execution resumes.
// (RULE5) Sleep with standby bit clear halts CPU, peripherals keep running.
// (RULE6) Interrupt or reset wakes sleep through the exception sequence.
// (RULE7) Sleep with standby bit set halts all, ports held, peripherals reset.
// (RULE8) Standby pin low halts everything, ports off, from any state.
// (RULE9) One bus state is one pclk period, edge to edge.
// (RULE10) On-chip memory cycles take two states, 16-bit path.
// (RULE11) Register field and external cycles take three states, one byte.
// (RULE12) Word on slow bus is two back-to-back byte cycles.
// (RULE13) Wait pin sampled mid second state; low adds a wait state.
// (RULE14) Wait resampled each wait state; held low stretches further.
// (RULE15) Reset pin low stops all work and initialises state.
// (RULE16) Reset sequence starts as soon as reset pin rises.
// (RULE17) Interrupts start only at instruction or sequence end.
// (RULE18) Reset source holds reset low 10 cycles, or 20 ms at power up.
// (RULE19) Reset release latches both mode pins into mode bits.
// (RULE20) Reset sets mask flag and initialises control registers.
// (RULE21) Reset vector word at address zero loads the PC.
// (RULE22) After reset all interrupts wait for first instruction end.
// (RULE23) Maskable interrupts stay off until software enables them.
// (RULE24) Wait sampled on falling edge, used at next rising edge.
// (RULE25) Standby bit selects sleep or software standby on sleep.
`timescale 1ns/1ps
module cpu_state_exception_bus_seq #(
   parameter logic [15:0] INT_MEM_END = 16'hf000
) (
   // Clock and bus reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device pins.
   input wire logic reset_in_n,
   input wire logic hw_standby_n,
   input wire logic wait_n,
   input wire logic op_mode_pin_hi,
   input wire logic op_mode_pin_lo,
   output logic op_mode_latched_hi,
   output logic op_mode_latched_lo,
   // CPU core side.
   input wire logic insn_done,
   input wire logic sleep_exec,
   input wire logic [15:0] pc_in,
   input wire logic [15:0] sp_in,
   input wire logic [6:0] ccr_flags_in,
   input wire logic ccr_i_wr,
   input wire logic ccr_i_val,
   output logic ccr_i_flag,
   output logic pc_load,
   output logic [15:0] pc_value,
   output logic sp_load,
   output logic [15:0] sp_value,
   // Interrupt requests.
   input wire logic nmi_req,
   input wire logic irq_req,
   input wire logic [15:0] irq_vec_addr,
   // Memory bus.
   input wire logic [15:0] rdata_in,
   output logic [15:0] bus_addr,
   output logic [15:0] bus_wdata,
   output logic bus_rd,
   output logic bus_wr,
   output logic bus_word,
   output logic bus_ext,
   output logic [2:0] bus_phase,
   // Power state.
   output logic cpu_halt,
   output logic periph_run,
   output logic periph_init,
   output logic port_hold,
   output logic port_off
);
   import cpu_seq_pkg::*;

   typedef struct packed {
      cpu_mode_t mode;
      bus_ph_t bph;
      logic [1:0] step;
      logic word_hi;
      logic bword;
      logic bext;
      logic brd;
      logic bwr;
      logic [15:0] baddr;
      logic [15:0] wfull;
      logic [15:0] bwd;
      logic [15:0] rbuf;
      logic [15:0] sp;
      logic [15:0] vec;
      logic [15:0] pc_val;
      logic [15:0] sp_val;
      logic pc_load;
      logic sp_load;
      logic seq_end;
      logic is_int;
      logic [NPIN-1:0] s1;
      logic [NPIN-1:0] s2;
      logic [NPIN-1:0] s3;
      logic [NPIN-1:0] pq;
      logic soft_standby_sel;
      logic irq_en;
      logic ibit;
      logic nmi_ok;
      logic nmi_pend;
      logic [1:0] mode_lat;
      logic cpu_halt;
      logic periph_run;
      logic periph_init;
      logic port_hold;
      logic port_off;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

   state_t r;
   state_t n;
   logic [NPIN-1:0] pins;
   logic wait_mid;
   logic done;
   logic take;
   logic [15:0] rd_word;
   logic [31:0] rd_mux;
   logic map_hit;

   assign pins = {op_mode_pin_hi, op_mode_pin_lo, wait_n, hw_standby_n,
                  reset_in_n};

   ////////////////////////////////////////////////////////////////////////
   // (RULE24) falling edge wait
   // The wait level is taken mid-state from the synchronised pin copy, so it
   // follows the pin several states late and settles before the next rising edge.
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_mid <= 1'b1;
      end else begin
         wait_mid <= r.pq[P_WAIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole block.
   always_comb begin
      n = r;
      done = 1'b0;
      n.pc_load = 1'b0;
      n.sp_load = 1'b0;
      n.seq_end = 1'b0;
      // Pin synchroniser; a change counts once stages two and three agree.
      n.s1 = pins;
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < NPIN; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            n.pq[i] = r.s3[i];
         end
      end
      rd_word = r.bext ? {r.rbuf[15:8], rdata_in[7:0]} : rdata_in;

      // (RULE9) one state per clock
      // Bus cycle engine advances one state per pclk.
      case (r.bph)
         bus_idle: begin
         end
         bus_state_first: begin
            n.bph = bus_state_second;
         end
         bus_state_second, bus_state_wait: begin
            // (RULE10) two-state internal cycle
            if (!r.bext) begin
               done = 1'b1;
            // (RULE13) insert wait state
            // (RULE14) repeat wait states
            end else if (!wait_mid) begin
               n.bph = bus_state_wait;
            end else begin
               n.bph = bus_state_third;
            end
         end
         bus_state_third: begin
            // (RULE11) three-state byte cycle
            // (RULE12) second byte follows
            if (r.bword && !r.word_hi) begin
               n.rbuf[15:8] = rdata_in[7:0];
               n.word_hi = 1'b1;
               n.baddr = r.baddr + 16'h0001;
               n.bph = bus_state_first;
            end else begin
               done = 1'b1;
            end
         end
         default: begin
            n.bph = bus_idle;
         end
      endcase
      if (done) begin
         n.bph = bus_idle;
         n.brd = 1'b0;
         n.bwr = 1'b0;
         n.word_hi = 1'b0;
      end

      // Interrupts are held off until the first instruction has ended.
      // (RULE22) block until first end
      // (RULE23) maskable needs enable
      take = (r.nmi_ok | insn_done) &
             (r.nmi_pend | (irq_req & r.irq_en & ~r.ibit));
      if (insn_done && r.mode == m_exec) begin
         n.nmi_ok = 1'b1;
      end

      // Mode sequencing.
      case (r.mode)
         m_reset: begin
            // (RULE16) start on release
            // (RULE19) latch mode pins
            // (RULE2) no pushes for reset
            n.mode_lat = {r.pq[P_MHI], r.pq[P_MLO]};
            // (RULE22) block interrupts again
            // A standby exit also passes here, so the mask and the
            // first-instruction hold are restored on every reset entry.
            n.ibit = 1'b1;
            n.nmi_ok = 1'b0;
            n.nmi_pend = 1'b0;
            n.mode = m_exc;
            n.step = 2'd2;
            n.vec = RESET_VEC_ADDR;
            n.is_int = 1'b0;
         end
         m_exec: begin
            // (RULE17) accept at boundary
            if (take && (insn_done || r.seq_end)) begin
               n.mode = m_exc;
            // (RULE25) sleep mode select
            // (RULE5) sleep keeps peripherals
            // (RULE7) software standby
            end else if (sleep_exec) begin
               n.mode = r.soft_standby_sel ? m_swstby : m_sleep;
            end
            if (ccr_i_wr) begin
               n.ibit = ccr_i_val;
            end
         end
         m_exc: begin
            // (RULE3) set mask flag
            if (r.step == 2'd2) begin
               n.ibit = 1'b1;
            end
            // (RULE4) load vector, resume
            if (done && r.step == 2'd2) begin
               n.pc_load = 1'b1;
               n.pc_val = rd_word;
               n.sp_load = r.is_int;
               n.sp_val = r.sp - STACK_WORD - STACK_WORD;
               n.mode = m_exec;
               n.seq_end = 1'b1;
            end else if (done) begin
               n.step = r.step + 2'd1;
            end
         end
         m_sleep, m_swstby: begin
            // (RULE6) wake through exception
            if (take) begin
               n.mode = m_exc;
            end
         end
         m_hwstby: begin
            n.mode = m_reset;
         end
         default: begin
            n.mode = m_reset;
         end
      endcase

      // Interrupt acceptance captures stack and vector.
      if (r.mode != m_exc && n.mode == m_exc && r.mode != m_reset) begin
         n.step = 2'd0;
         n.sp = sp_in;
         n.is_int = 1'b1;
         n.vec = r.nmi_pend ? NMI_VEC_ADDR : irq_vec_addr;
         n.nmi_pend = 1'b0;
      end
      // A new request in the accepting cycle still sets the flag.
      if (nmi_req) begin
         n.nmi_pend = 1'b1;
      end

      // (RULE2) push PC then COND_CODE_REG
      // Launch the bus cycle for the current sequence step.
      if (r.mode == m_exc && r.bph == bus_idle) begin
         n.bph = bus_state_first;
         n.word_hi = 1'b0;
         n.bword = 1'b1;
         case (r.step)
            2'd0: begin
               n.baddr = r.sp - STACK_WORD;
               n.wfull = pc_in;
               n.bwr = 1'b1;
            end
            2'd1: begin
               n.baddr = r.sp - STACK_WORD - STACK_WORD;
               n.wfull = {r.ibit, ccr_flags_in, r.ibit, ccr_flags_in};
               n.bwr = 1'b1;
            end
            default: begin
               // (RULE21) fetch vector word
               n.baddr = r.vec;
               n.brd = 1'b1;
            end
         endcase
      end

      // APB slave: answer one cycle into the access phase.
      map_hit = (paddr == OFF_CTRL) || (paddr == OFF_STAT) ||
                (paddr == OFF_MODE);
      rd_mux = 32'h0000_0000;
      case (paddr)
         OFF_CTRL: begin
            rd_mux[CTRL_SOFT_STANDBY_SEL_BIT] = r.soft_standby_sel;
            rd_mux[CTRL_IEN_BIT] = r.irq_en;
         end
         OFF_STAT: begin
            rd_mux[ST_I_BIT] = r.ibit;
            rd_mux[ST_NMI_OK_BIT] = r.nmi_ok;
            rd_mux[ST_MODE_LSB +: 3] = r.mode;
            rd_mux[ST_BUS_LSB +: 3] = r.bph;
         end
         OFF_MODE: begin
            rd_mux[1:0] = r.mode_lat;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel && penable && !r.pready) begin
         n.pready = 1'b1;
         n.pslverr = !map_hit;
         n.prdata = (map_hit && !pwrite) ? rd_mux : 32'h0000_0000;
      end
      if (psel && penable && r.pready && pwrite && paddr == OFF_CTRL) begin
         n.soft_standby_sel = pwdata[CTRL_SOFT_STANDBY_SEL_BIT];
         n.irq_en = pwdata[CTRL_IEN_BIT];
      end

      // (RULE8) hardware standby
      // (RULE1) reset priority
      // (RULE15) reset stops all
      // (RULE20) reset initialises
      if (!r.pq[P_HW_STANDBY_N] || !r.pq[P_RES]) begin
         n.mode = r.pq[P_HW_STANDBY_N] ? m_reset : m_hwstby;
         n.bph = bus_idle;
         n.brd = 1'b0;
         n.bwr = 1'b0;
         n.word_hi = 1'b0;
         n.soft_standby_sel = 1'b0;
         n.irq_en = 1'b0;
         n.pc_load = 1'b0;
         n.sp_load = 1'b0;
         n.seq_end = 1'b0;
         if (r.pq[P_HW_STANDBY_N]) begin
            n.ibit = 1'b1;
            n.nmi_ok = 1'b0;
            n.nmi_pend = 1'b0;
         end
      end

      // Registered copies of outputs, so every port is a flip-flop.
      n.bext = n.baddr >= INT_MEM_END;
      if (!n.bext) begin
         n.bwd = n.wfull;
      end else if (n.word_hi) begin
         n.bwd = {8'h00, n.wfull[7:0]};
      end else begin
         n.bwd = {8'h00, n.wfull[15:8]};
      end
      n.cpu_halt = n.mode != m_exec;
      n.periph_run = n.mode == m_exec || n.mode == m_exc ||
                     n.mode == m_sleep;
      n.periph_init = !n.periph_run;
      n.port_hold = n.mode == m_swstby;
      n.port_off = n.mode == m_hwstby;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.mode <= m_reset;
         r.bph <= bus_idle;
         r.ibit <= 1'b1;
         r.s1 <= PIN_RESET_VAL;
         r.s2 <= PIN_RESET_VAL;
         r.s3 <= PIN_RESET_VAL;
         r.pq <= PIN_RESET_VAL;
         r.cpu_halt <= 1'b1;
         r.periph_init <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Output wiring straight from the state register.
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign op_mode_latched_hi = r.mode_lat[1];
   assign op_mode_latched_lo = r.mode_lat[0];
   assign ccr_i_flag = r.ibit;
   assign pc_load = r.pc_load;
   assign pc_value = r.pc_val;
   assign sp_load = r.sp_load;
   assign sp_value = r.sp_val;
   assign bus_addr = r.baddr;
   assign bus_wdata = r.bwd;
   assign bus_rd = r.brd;
   assign bus_wr = r.bwr;
   assign bus_word = r.bword;
   assign bus_ext = r.bext;
   assign bus_phase = r.bph;
   assign cpu_halt = r.cpu_halt;
   assign periph_run = r.periph_run;
   assign periph_init = r.periph_init;
   assign port_hold = r.port_hold;
   assign port_off = r.port_off;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer.
   AST_RST_PRIO: assert property ( // (RULE1)
      @(posedge pclk) disable iff (!presetn)
      (!r.pq[P_RES] && r.pq[P_HW_STANDBY_N]) |=> (r.mode == m_reset && !r.pc_load))
      else $error("reset pin did not force reset state");
   AST_RST_NOPUSH: assert property ( // (RULE2)
      @(posedge pclk) disable iff (!presetn)
      (r.mode == m_reset && r.pq[P_RES] && r.pq[P_HW_STANDBY_N])
      |=> (r.mode == m_exc && r.step == 2'd2 && r.vec == RESET_VEC_ADDR))
      else $error("reset sequence did not go straight to vector fetch");
   AST_MASK_SET: assert property ( // (RULE3)
      @(posedge pclk) disable iff (!presetn)
      (r.mode == m_exc && r.step == 2'd2) |=> r.ibit)
      else $error("mask flag not set in exception sequence");
   AST_VEC_LOAD: assert property ( // (RULE4)
      @(posedge pclk) disable iff (!presetn)
      r.pc_load |-> (r.mode == m_exec && $past(r.mode) == m_exc &&
                     r.pc_val == $past(rd_word)))
      else $error("PC load not from vector fetch");
   AST_SLEEP_SEL: assert property ( // (RULE25)
      @(posedge pclk) disable iff (!presetn)
      (r.mode == m_exec && sleep_exec && !insn_done && r.pq[P_RES] &&
       r.pq[P_HW_STANDBY_N]) |=> (r.mode == ($past(r.soft_standby_sel) ? m_swstby : m_sleep))
      ##0 (r.periph_run == !$past(r.soft_standby_sel)))
      else $error("sleep did not select the right power mode");
   AST_HW_HW_STANDBY_N: assert property ( // (RULE8)
      @(posedge pclk) disable iff (!presetn)
      !r.pq[P_HW_STANDBY_N] |=> (r.mode == m_hwstby && r.port_off && r.cpu_halt))
      else $error("standby pin did not halt the device");
   AST_INT_CYCLE: assert property ( // (RULE10)
      @(posedge pclk) disable iff (!presetn)
      (r.bph == bus_state_first && !r.bext)
      |=> (r.bph == bus_state_second || r.bph == bus_idle)
      ##1 (r.bph == bus_idle || r.bph == bus_state_first))
      else $error("on-chip memory cycle not two states");
   AST_WAIT_INS: assert property ( // (RULE13)
      @(posedge pclk) disable iff (!presetn)
      ((r.bph == bus_state_second || r.bph == bus_state_wait) && r.bext &&
       r.pq[P_RES] && r.pq[P_HW_STANDBY_N])
      |=> (r.bph == ($past(wait_mid) ? bus_state_third : bus_state_wait)))
      else $error("wait state decision wrong");
   AST_WORD_SPLIT: assert property ( // (RULE12)
      @(posedge pclk) disable iff (!presetn)
      (r.bph == bus_state_third && r.bword && !r.word_hi &&
       r.pq[P_RES] && r.pq[P_HW_STANDBY_N])
      |=> (r.bph == bus_state_first && r.word_hi &&
           r.baddr == $past(r.baddr) + 16'h0001))
      else $error("word not split into two byte cycles");
   AST_NMI_HOLD: assert property ( // (RULE22)
      @(posedge pclk) disable iff (!presetn)
      (r.mode == m_exec && !r.nmi_ok && !insn_done) |=> (r.mode != m_exc))
      else $error("interrupt taken before first instruction end");
   AST_MODE_LATCH: assert property ( // (RULE19)
      @(posedge pclk) disable iff (!presetn)
      (r.mode == m_reset && r.pq[P_RES] && r.pq[P_HW_STANDBY_N])
      |=> (r.mode_lat == $past({r.pq[P_MHI], r.pq[P_MLO]})))
      else $error("mode pins not latched at reset release");
endmodule

// File: rtl/cpu_seq_pkg.sv
// Constants, pin indices and state encodings for the CPU state sequencer.
// Assumes a 250 MHz pclk and registers reached over APB.
package cpu_seq_pkg;
   // Register byte offsets on APB.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   // Control register fields.
   localparam int CTRL_SOFT_STANDBY_SEL_BIT = 0;
   localparam int CTRL_IEN_BIT = 1;
   // Status register fields.
   localparam int ST_I_BIT = 0;
   localparam int ST_NMI_OK_BIT = 1;
   localparam int ST_MODE_LSB = 2;
   localparam int ST_BUS_LSB = 5;
   // Condition code interrupt mask position.
   localparam int CCR_I_BIT = 7;
   // Vector and stack constants.
   localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
   localparam logic [15:0] NMI_VEC_ADDR = 16'h0006;
   localparam logic [15:0] STACK_WORD = 16'h0002;
   // Pin indices inside the synchronised pin vector.
   localparam int NPIN = 5;
   localparam int P_RES = 0;
   localparam int P_HW_STANDBY_N = 1;
   localparam int P_WAIT = 2;
   localparam int P_MLO = 3;
   localparam int P_MHI = 4;
   // Pins look like reset held, standby off, no wait until sampled.
   localparam logic [NPIN-1:0] PIN_RESET_VAL = 5'h06;
   // Least reset pulse during operation, and at power up.
   localparam int RST_MIN_CYC = 10;
   localparam int RST_PWR_MS = 20;
   // Operating modes of the CPU.
   typedef enum logic [2:0] {
      m_reset, m_exec, m_exc, m_sleep, m_swstby, m_hwstby
   } cpu_mode_t;
   // Bus cycle states.
   typedef enum logic [2:0] {
      bus_idle, bus_state_first, bus_state_second,
      bus_state_wait, bus_state_third
   } bus_ph_t;
endpackage

// File: verif/seq_mem_model.sv
// Memory and wait-pin partner on the far side of the sequencer bus.
// Assumes it shares pclk with the sequencer; the wait pin has a pull-up.
`timescale 1ns/1ps
module seq_mem_model (
   // Clock.
   input wire logic pclk,
   // Bus from the sequencer.
   input wire logic [15:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_ext,
   input wire logic [2:0] bus_phase,
   // Bench control: wait states wanted per slow cycle.
   input wire logic [7:0] n_wait,
   // Answers.
   output logic [15:0] rdata_in,
   output logic wait_n
);
   logic [7:0] wcnt;
   initial begin
      rdata_in = 16'h0f0f;
      wait_n = 1'b1;
      wcnt = 8'h00;
   end
   ////////////////////////////////////////
   // Read data; an idle bus shows the inverse of the last value, so a
   // late sample can never pass for the right one.
   always @(posedge pclk) begin
      if (bus_rd) begin
         rdata_in <= bus_ext ? {~bus_addr[7:0], bus_addr[7:0] ^ 8'h5a} :
            {bus_addr[7:0] ^ 8'ha5, bus_addr[7:0] ^ 8'h3c};
      end else begin
         rdata_in <= ~rdata_in;
      end
   end
   // hold wait low
   // The sequencer sees wait only through its pin synchroniser, so a slow
   // device drives it low ahead of the cycle and lets go once n_wait
   // wait states have passed.
   always @(posedge pclk) begin
      wcnt <= (bus_phase == 3'h0) ? 8'h00 : wcnt + {7'h0, bus_phase == 3'h3};
      wait_n <= !(wcnt < n_wait);
   end
endmodule

// File: verif/cpu_state_exception_bus_seq_bench.sv
// Self-checking bench for the CPU state sequencer.
// Assumes the memory partner model and an APB master built here.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cpu_state_exception_bus_seq_bench;
   import cpu_seq_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, n_wait;
   logic [31:0] pwdata, prdata, rd;
   logic reset_in_n, hw_standby_n, wait_n, mhi, mlo, lhi, llo, er;
   logic insn_done, sleep_exec, ccr_i_wr, ccr_i_val, ccr_i_flag, pc_load;
   logic sp_load, nmi_req, irq_req, bus_rd, bus_wr, bus_ext, bus_word;
   logic [15:0] bus_wdata;
   logic [17:0] wd[$];
   logic cpu_halt, periph_run, periph_init, port_hold, port_off;
   logic [15:0] pc_value, sp_value, sp_in, irq_vec_addr, rdata_in, bus_addr;
   logic [2:0] bus_phase;
   logic [16:0] acc[$];
   int lens[$], waits[$], cur, nw, n_errors, n_tests;
   cpu_state_exception_bus_seq u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_in_n(reset_in_n), .hw_standby_n(hw_standby_n), .wait_n(wait_n),
      .op_mode_pin_hi(mhi), .op_mode_pin_lo(mlo), .op_mode_latched_hi(lhi),
      .op_mode_latched_lo(llo), .insn_done(insn_done),
      .sleep_exec(sleep_exec), .pc_in(16'h1234), .sp_in(sp_in),
      .ccr_flags_in(7'h55), .ccr_i_wr(ccr_i_wr), .ccr_i_val(ccr_i_val),
      .ccr_i_flag(ccr_i_flag), .pc_load(pc_load), .pc_value(pc_value),
      .sp_load(sp_load), .sp_value(sp_value), .nmi_req(nmi_req),
      .irq_req(irq_req), .irq_vec_addr(irq_vec_addr), .rdata_in(rdata_in),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_word(bus_word), .bus_ext(bus_ext),
      .bus_phase(bus_phase),
      .cpu_halt(cpu_halt), .periph_run(periph_run),
      .periph_init(periph_init), .port_hold(port_hold), .port_off(port_off));
   seq_mem_model u_mem (.pclk(pclk), .bus_addr(bus_addr), .bus_rd(bus_rd),
      .bus_ext(bus_ext), .bus_phase(bus_phase), .n_wait(n_wait),
      .rdata_in(rdata_in), .wait_n(wait_n));
   ////////////////////////////////////////
   // Bus monitor at the falling edge, where the registered bus is settled:
   // one entry per byte or word cycle, so slow word halves count apart.
   always @(negedge pclk) begin
      if (cur != 0 && (bus_phase == 3'h0 || bus_phase == 3'h1)) begin
         lens.push_back(cur);
         waits.push_back(nw);
         cur = 0;
         nw = 0;
      end
      if (bus_phase == 3'h1) acc.push_back({bus_wr, bus_addr});
      if (bus_phase == 3'h1 && bus_wr) begin
         wd.push_back({bus_ext, bus_word, bus_wdata});
      end
      if (bus_phase != 3'h0) begin
         cur++;
         nw += int'(bus_phase == 3'h3);
      end
   end
   ////////////////////////////////////////
   task summarize;
      $display("errors=%0d checks=%0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // APB transfer; the request stands until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // One-cycle pulse on sleep_exec, nmi_req, insn_done.
   task kick(input logic [2:0] m);
      @(posedge pclk) {sleep_exec, nmi_req, insn_done} <= m;
      @(posedge pclk) {sleep_exec, nmi_req, insn_done} <= 3'h0;
   endtask
   task wait_pc;
      for (int i = 0; i < 400 && pc_load !== 1'b1; i++) @(posedge pclk);
      `CHK(pc_load, 1'b1)
   endtask
   task clr;
      acc.delete();
      lens.delete();
      waits.delete();
      wd.delete();
   endtask
   ////////////////////////////////////////
   task t_reset;
      `CHK({ccr_i_flag, cpu_halt, periph_init}, 3'h7)
      @(posedge pclk) presetn <= 1'b1;
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 8'h3c, 32'h0);
      `CHK(er, 1'b1)
      clr();
      reset_in_n <= 1'b1;
      wait_pc();
      `CHK(pc_value, 16'ha53c)
      `CHK(acc[0], 17'h00000)
      `CHK(lens[0], 2)
      `CHK({lhi, llo}, 2'b10)
      `CHK(ccr_i_flag, 1'b1)
   endtask
   task t_nmi;
      clr();
      kick(3'h2);
      repeat (12) @(posedge pclk);
      `CHK(acc.size(), 0)
      kick(3'h1);
      wait_pc();
      `CHK(pc_value, 16'ha33a)
      `CHK({sp_load, sp_value}, 17'h10efc)
      `CHK(acc[0], 17'h10efe)
      `CHK(acc[1], 17'h10efc)
      `CHK(acc[2], 17'h00006)
      `CHK(wd[0], 18'h11234)
      `CHK(wd[1], 18'h1d5d5)
      `CHK(lens[1], 2)
      `CHK(ccr_i_flag, 1'b1)
   endtask
   task t_irq;
      clr();
      {n_wait, irq_req, ccr_i_wr} <= {8'h2, 2'b11};
      @(posedge pclk) ccr_i_wr <= 1'b0;
      kick(3'h1);
      repeat (10) @(posedge pclk);
      `CHK(acc.size(), 0)
      apb(1'b1, OFF_CTRL, 32'h2);
      kick(3'h1);
      wait_pc();
      irq_req <= 1'b0;
      `CHK(pc_value, 16'h4a4b)
      `CHK(acc[2], 17'h0f010)
      `CHK(acc[3], 17'h0f011)
      `CHK(lens[3] - waits[3], 3)
      `CHK(waits[3], 0)
      // Two waits asked for; the release crosses the pin synchroniser and
      // reaches the mid-state sampler six states later.
      `CHK(waits[2], 8)
   endtask
   task t_sleep(input logic ss);
      apb(1'b1, OFF_CTRL, {31'h0, ss});
      kick(3'h4);
      repeat (3) @(posedge pclk);
      `CHK({cpu_halt, periph_run, port_hold}, {1'b1, !ss, ss})
      apb(1'b0, OFF_STAT, 32'h0);
      `CHK(rd[4:2], ss ? 3'h4 : 3'h3)
      kick(3'h2);
      wait_pc();
      `CHK(pc_value, 16'ha33a)
   endtask
   task t_hwstby;
      hw_standby_n <= 1'b0;
      for (int i = 0; i < 20 && port_off !== 1'b1; i++) @(posedge pclk);
      `CHK({port_off, cpu_halt, periph_init}, 3'h7)
      hw_standby_n <= 1'b1;
      wait_pc();
      `CHK(pc_value, 16'ha53c)
   endtask
   task t_pinreset;
      {sp_in, n_wait, mhi, mlo} <= {16'hff00, 8'd60, 2'b01};
      kick(3'h3);
      kick(3'h1);
      for (int i = 0; i < 40 && bus_phase !== 3'h3; i++) @(posedge pclk);
      `CHK(bus_phase, 3'h3)
      `CHK(wd[$], 18'h30012)
      reset_in_n <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK({bus_phase, bus_rd, bus_wr, ccr_i_flag}, 6'h01)
      repeat (10) @(posedge pclk);
      reset_in_n <= 1'b1;
      wait_pc();
      `CHK(pc_value, 16'ha53c)
      `CHK({lhi, llo}, 2'b01)
   endtask
   ////////////////////////////////////////
   // Clock, reset for 20 cycles, then the scenarios in order.
   initial begin
      pclk = 0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {reset_in_n, hw_standby_n, mhi, mlo, n_wait} = {4'b0110, 8'h0};
      {insn_done, sleep_exec, ccr_i_wr, ccr_i_val, nmi_req} = '0;
      {irq_req, sp_in, irq_vec_addr} = {1'b0, 16'h0f00, 16'hf010};
      repeat (20) @(posedge pclk);
      t_reset();
      t_nmi();
      t_irq();
      t_sleep(1'b0);
      t_sleep(1'b1);
      t_hwstby();
      t_pinreset();
      summarize();
   end
   // Watchdog: the scenarios need a few thousand cycles at most.
   initial begin
      #80000;
      n_errors++;
      summarize();
   end
endmodule
